// File: spc_defs.svh
// Constants of the serial processor companion: opcodes, register indices,
// control field positions, reset values and timing figures.
// Assumes a 40 MHz system clock and an 8-bit register index space.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_CLK_HZ          40000000
`define SPC_OP_WRITE        8'h52
`define SPC_OP_READ         8'h51
`define SPC_REG_CTRL        8'h00
`define SPC_REG_WD_TIMEOUT  8'h01
`define SPC_REG_WD_WINDOW   8'h02
`define SPC_REG_WD_RESTART  8'h03
`define SPC_REG_STATUS      8'h04
`define SPC_REG_CNT_LO      8'h05
`define SPC_REG_CNT_HI      8'h06
`define SPC_REG_SN_LOCK     8'h07
`define SPC_REG_SN_BASE     5'h01
`define SPC_REG_CAL_BASE    5'h02
`define SPC_REG_ALM_MIN     8'h18
`define SPC_REG_ALM_HOUR    8'h19
`define SPC_CTRL_WD_EN      0
`define SPC_CTRL_CNT_POL    1
`define SPC_CTRL_CNT_BAK    2
`define SPC_CTRL_ACS_LSB    3
`define SPC_CTRL_SQW_LSB    5
`define SPC_ST_WD_SRC       0
`define SPC_ST_ALARM        1
`define SPC_ST_OVERRUN      2
`define SPC_ST_LOCK         3
`define SPC_WD_KEY          8'ha5
`define SPC_RST_HOLD_MS     100
`define SPC_WD_PULSE_MS     100
`define SPC_WD_STEP_MS      60
`define SPC_WD_MAX_MS       1800
`define SPC_MR_DEBOUNCE_MS  10
`define SPC_SYNC_RST        8'h11
`endif

// File: spc_pkg.sv
// Types of the serial processor companion.
// Assumes nothing beyond the compile order.
`default_nettype none
package spc_pkg;
  typedef enum logic [2:0] {
    SPC_IDLE   = 3'b000,
    SPC_OPCODE = 3'b001,
    SPC_ADDR   = 3'b010,
    SPC_WDATA  = 3'b011,
    SPC_RDATA  = 3'b100,
    SPC_SKIP   = 3'b101
  } spc_frame_type;
  typedef enum logic [1:0] {
    SPC_ACS_ALARM = 2'b00,
    SPC_ACS_CAL   = 2'b01,
    SPC_ACS_SQW   = 2'b10,
    SPC_ACS_OFF   = 2'b11
  } spc_acs_type;
endpackage : spc_pkg
`default_nettype wire

// File: spc_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic [2:0] stage;
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          stage <= {3{RESET_VAL[g]}};
        end else begin
          stage <= {stage[1:0], async_i[g]};
        end
      end
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          level_o[g] <= RESET_VAL[g];
        end else if (stage[1] == stage[2]) begin
          level_o[g] <= stage[2];
        end
      end
    end
  endgenerate
endmodule : spc_sync
`default_nettype wire

// File: spc_fifo.sv
// Register-write FIFO between the serial receiver and the register file.
// Assumes DEPTH is a power of two; full and empty come from wrap-bit pointers.
`timescale 1ns/100ps
`default_nettype none
module spc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
    end else if (in_valid_i && in_ready_o) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_ptr <= '0;
    end else if (out_valid_o && out_ready_i) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : spc_fifo
`default_nettype wire

// File: spc_top.sv
// Serial slave front end and companion functions: supervisor, watchdog,
// event counter, alarm/wave output, serial number and BCD calendar.
// Assumes all pins asynchronous to mclk_i and a 32.768 kHz oscillator pin.
`include "spc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
// Function
// - Chip select high: ignore link, float output.
// - Transfers timed by host serial clock edges.
// - Capture on rising edge, shift on falling.
// - Fully static link, no frame timeouts.
// - Modes 0,0 and 1,1 by idle level.
// - Drive output only while returning read data.
// - Sixteen-bit counter, one per detected edge.
// - Polarity selects rising or falling edges.
// - Backup mode keeps counting without main supply.
// - Normal mode: active-low open-drain alarm.
// - Calibration mode: 512 Hz from oscillator.
// - Reset held at most 100 ms after recovery.
// - Watchdog timeout 60 ms to 1.8 s.
// - Delayed start forms a restart window.
// - Missed window pulses reset 100 ms; disabled idle.
// - Flag records low supply or watchdog source.
// - Manual reset pin input filtered and debounced.
// - Lockable 64-bit serial number, locked writes ignored.
// - BCD calendar from seconds to centuries.
// - Leap years correct through 2099.
// - Companion answers only its own opcodes.
// - Ignore link while reset asserted; finish writes.
// - Square wave selects one of four frequencies.
module spc_top #(
  parameter int MS_CYC     = `SPC_CLK_HZ / 1000,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  input  wire logic          spi_cs_n_i,
  input  wire logic          spi_sck_i,
  input  wire logic          spi_si_i,
  output logic               spi_so_o,
  output logic               spi_so_oe_o,
  input  wire logic          event_count_input_i,
  input  wire logic          supply_low_i,
  input  wire logic          power_fail_sense_input_i,
  output logic               power_fail_warning_output_n_o,
  input  wire logic          osc_32k_i,
  input  wire logic          rst_pin_i,
  output logic               rst_pin_o,
  output logic               rst_pin_oe_o,
  output logic               alarm_cal_wave_output_o,
  output logic               alarm_cal_wave_output_oe_o,
  output spc_pkg::spc_acs_type acs_mode_o,
  output logic               standby_o,
  output logic               reset_active_o,
  output logic               reset_from_watchdog_o
);
  import spc_pkg::*;

  logic [7:0]    pins_f;
  logic          cs_n_f, sck_f, si_f, cnt_f, rstp_f, vlow_f, pfs_f, osc_f;
  logic          cs_q, sck_q, cnt_q, osc_q;
  spc_frame_type frame;
  logic [2:0]    bit_cnt;
  logic [6:0]    shreg;
  logic [7:0]    rx_byte, addr, rd_idx, rd_data, tx_buf, tx_sh;
  logic          is_read, load_pend, push, fifo_ready;
  logic [15:0]   fifo_out;
  logic          fifo_valid, drain_ready, wr_en;
  logic [7:0]    waddr, wdata;
  logic [7:0]    ctrl, wd_timeout, wd_window;
  logic          wd_src, alarm_flag, overrun, sn_lock, match_q;
  logic [7:0]    sn [0:7];
  logic [7:0]    cal [0:6];
  logic [7:0]    alm_min, alm_hour;
  logic [15:0]   evt_count;
  logic [14:0]   presc;
  logic          sec_tick, ms_tick;
  logic [15:0]   ms_cnt, wd_ms, wd_limit, wd_open;
  logic [4:0]    wd_steps, win_steps;
  logic          wd_kick, wd_fail, reset_active, mr_trig;
  logic [7:0]    hold_ms, mr_ms;
  logic          acs_drive_low;

  spc_sync #(
    .WIDTH     (8),
    .RESET_VAL (`SPC_SYNC_RST)
  ) u_sync (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .async_i ({osc_32k_i, power_fail_sense_input_i, supply_low_i, rst_pin_i,
               event_count_input_i, spi_si_i, spi_sck_i, spi_cs_n_i}),
    .level_o (pins_f)
  );
  assign {osc_f, pfs_f, vlow_f, rstp_f, cnt_f, si_f, sck_f, cs_n_f} = pins_f;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {cs_q, sck_q, cnt_q, osc_q} <= 4'h8;
    end else begin
      {cs_q, sck_q, cnt_q, osc_q} <= {cs_n_f, sck_f, cnt_f, osc_f};
    end
  end

  // Serial frame engine
  assign rx_byte = {shreg, si_f};
  assign rd_idx  = (frame == SPC_ADDR) ? rx_byte : addr + 8'h01;
  assign push    = sck_f && !sck_q && !cs_n_f && (frame == SPC_WDATA) && (bit_cnt == 3'h7);
  assign standby_o = cs_n_f;
  assign spi_so_oe_o = (frame == SPC_RDATA) && !cs_n_f;

  always_ff @(posedge mclk_i) begin
    if (srst_i || cs_n_f) begin
      frame     <= SPC_IDLE;
      spi_so_o  <= 1'b0;
      bit_cnt   <= 3'h0;
      is_read   <= 1'b0;
      load_pend <= 1'b0;
    end else if (cs_q && !cs_n_f) begin
      frame   <= reset_active ? SPC_SKIP : SPC_OPCODE;
      bit_cnt <= 3'h0;
    end else if (reset_active) begin
      frame <= SPC_SKIP;
    end else if (sck_f && !sck_q && frame != SPC_SKIP && frame != SPC_IDLE) begin
      shreg   <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (frame)
          SPC_OPCODE: begin
            if (rx_byte == `SPC_OP_WRITE) begin
              frame   <= SPC_ADDR;
              is_read <= 1'b0;
            end else if (rx_byte == `SPC_OP_READ) begin
              frame   <= SPC_ADDR;
              is_read <= 1'b1;
            end else begin
              frame <= SPC_SKIP;
            end
          end
          SPC_ADDR: begin
            addr      <= rx_byte;
            frame     <= is_read ? SPC_RDATA : SPC_WDATA;
            tx_buf    <= rd_data;
            load_pend <= is_read;
          end
          SPC_WDATA: addr <= addr + 8'h01;
          SPC_RDATA: begin
            addr      <= addr + 8'h01;
            tx_buf    <= rd_data;
            load_pend <= 1'b1;
          end
          default: frame <= frame;
        endcase
      end
    end else if (sck_f == 1'b0 && sck_q && frame == SPC_RDATA) begin
      if (load_pend) begin
        spi_so_o  <= tx_buf[7];
        tx_sh     <= {tx_buf[6:0], 1'b0};
        load_pend <= 1'b0;
      end else begin
        spi_so_o <= tx_sh[7];
        tx_sh    <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // Writes queue here; the drain stalls on a calendar tick so neither is lost
  spc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_data_i   ({addr, rx_byte}),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (drain_ready)
  );
  assign drain_ready = !sec_tick;
  assign wr_en = fifo_valid && drain_ready;
  assign {waddr, wdata} = fifo_out;

  always_comb begin
    rd_data = 8'h00;
    if (rd_idx == `SPC_REG_CTRL) begin
      rd_data = ctrl;
    end else if (rd_idx == `SPC_REG_WD_TIMEOUT) begin
      rd_data = wd_timeout;
    end else if (rd_idx == `SPC_REG_WD_WINDOW) begin
      rd_data = wd_window;
    end else if (rd_idx == `SPC_REG_STATUS) begin
      rd_data = {4'h0, sn_lock, overrun, alarm_flag, wd_src};
    end else if (rd_idx == `SPC_REG_CNT_LO) begin
      rd_data = evt_count[7:0];
    end else if (rd_idx == `SPC_REG_CNT_HI) begin
      rd_data = evt_count[15:8];
    end else if (rd_idx == `SPC_REG_SN_LOCK) begin
      rd_data = {7'h00, sn_lock};
    end else if (rd_idx[7:3] == `SPC_REG_SN_BASE) begin
      rd_data = sn[rd_idx[2:0]];
    end else if (rd_idx[7:3] == `SPC_REG_CAL_BASE && rd_idx[2:0] != 3'h7) begin
      rd_data = cal[rd_idx[2:0]];
    end else if (rd_idx == `SPC_REG_ALM_MIN) begin
      rd_data = alm_min;
    end else if (rd_idx == `SPC_REG_ALM_HOUR) begin
      rd_data = alm_hour;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl       <= 8'h00;
      wd_timeout <= 8'h1e;
      wd_window  <= 8'h00;
      alm_min    <= 8'h00;
      alm_hour   <= 8'h00;
    end else if (wr_en) begin
      if (waddr == `SPC_REG_CTRL) begin
        ctrl <= wdata;
      end else if (waddr == `SPC_REG_WD_TIMEOUT) begin
        wd_timeout <= wdata;
      end else if (waddr == `SPC_REG_WD_WINDOW) begin
        wd_window <= wdata;
      end else if (waddr == `SPC_REG_ALM_MIN) begin
        alm_min <= wdata;
      end else if (waddr == `SPC_REG_ALM_HOUR) begin
        alm_hour <= wdata;
      end
    end
  end

  // Serial number; the lock only clears at reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sn_lock <= 1'b0;
    end else if (wr_en && waddr == `SPC_REG_SN_LOCK && wdata[0]) begin
      sn_lock <= 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sn <= '{default: 8'h00};
    end else if (wr_en && waddr[7:3] == `SPC_REG_SN_BASE && !sn_lock) begin
      sn[waddr[2:0]] <= wdata;
    end
  end

  // Status flags: hardware set wins over a write-one clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      overrun <= 1'b0;
    end else if (push && !fifo_ready) begin
      overrun <= 1'b1;
    end else if (wr_en && waddr == `SPC_REG_STATUS && wdata[`SPC_ST_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      alarm_flag <= 1'b0;
      match_q    <= 1'b1; // Avoids a false alarm at reset time
    end else begin
      match_q <= (cal[0] == 8'h00) && (cal[1] == alm_min) && (cal[2] == alm_hour);
      if ((cal[0] == 8'h00) && (cal[1] == alm_min) && (cal[2] == alm_hour) && !match_q) begin
        alarm_flag <= 1'b1;
      end else if (wr_en && waddr == `SPC_REG_STATUS && wdata[`SPC_ST_ALARM]) begin
        alarm_flag <= 1'b0;
      end
    end
  end

  // Event counter
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      evt_count <= 16'h0000;
    end else if ((ctrl[`SPC_CTRL_CNT_POL] ? (cnt_q && !cnt_f) : (cnt_f && !cnt_q))
                 && (!vlow_f || ctrl[`SPC_CTRL_CNT_BAK])) begin
      evt_count <= evt_count + 16'h0001;
    end
  end

  // Oscillator prescaler and calendar
  assign sec_tick = osc_f && !osc_q && (presc == 15'h7fff);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      presc <= 15'h0000;
    end else if (osc_f && !osc_q) begin
      presc <= presc + 15'h0001;
    end
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default:                    month_days = 8'h31;
    endcase
  endfunction : month_days

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cal <= '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h20};
    end else if (sec_tick) begin
      cal[0] <= bcd_inc(cal[0]);
      if (cal[0] == 8'h59) begin
        cal[0] <= 8'h00;
        cal[1] <= bcd_inc(cal[1]);
        if (cal[1] == 8'h59) begin
          cal[1] <= 8'h00;
          cal[2] <= bcd_inc(cal[2]);
          if (cal[2] == 8'h23) begin
            cal[2] <= 8'h00;
            cal[3] <= bcd_inc(cal[3]);
            if (cal[3] == month_days(cal[4], cal[5])) begin
              cal[3] <= 8'h01;
              cal[4] <= bcd_inc(cal[4]);
              if (cal[4] == 8'h12) begin
                cal[4] <= 8'h01;
                cal[5] <= bcd_inc(cal[5]);
                if (cal[5] == 8'h99) begin
                  cal[5] <= 8'h00;
                  cal[6] <= bcd_inc(cal[6]);
                end
              end
            end
          end
        end
      end
    end else if (wr_en && waddr[7:3] == `SPC_REG_CAL_BASE && waddr[2:0] != 3'h7) begin
      cal[waddr[2:0]] <= wdata;
    end
  end

  // Alarm, calibration and square-wave pin; drive low or release
  assign acs_mode_o = spc_acs_type'(ctrl[`SPC_CTRL_ACS_LSB +: 2]);
  assign alarm_cal_wave_output_o = 1'b0;
  always_comb begin
    case (acs_mode_o)
      SPC_ACS_ALARM: acs_drive_low = alarm_flag;
      SPC_ACS_CAL:   acs_drive_low = !presc[5];
      SPC_ACS_SQW: begin
        case (ctrl[`SPC_CTRL_SQW_LSB +: 2])
          2'h0:    acs_drive_low = !presc[14];
          2'h1:    acs_drive_low = !presc[5];
          2'h2:    acs_drive_low = !presc[2];
          default: acs_drive_low = !osc_f;
        endcase
      end
      default: acs_drive_low = 1'b0;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      alarm_cal_wave_output_oe_o    <= 1'b0;
      power_fail_warning_output_n_o <= 1'b1;
    end else begin
      alarm_cal_wave_output_oe_o    <= acs_drive_low;
      power_fail_warning_output_n_o <= !pfs_f;
    end
  end

  // Millisecond time base shared by watchdog, reset hold and debounce
  assign ms_tick = (ms_cnt == 16'(MS_CYC - 1));
  always_ff @(posedge mclk_i) begin
    if (srst_i || ms_tick) begin
      ms_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  // Windowed watchdog in 60 ms steps
  assign wd_steps  = (wd_timeout[4:0] == 5'h00) ? 5'h01
                   : (wd_timeout[4:0] > 5'(`SPC_WD_MAX_MS / `SPC_WD_STEP_MS))
                   ? 5'(`SPC_WD_MAX_MS / `SPC_WD_STEP_MS) : wd_timeout[4:0];
  assign win_steps = (wd_window[4:0] < wd_steps) ? wd_window[4:0] : 5'h00;
  assign wd_limit  = 16'({11'h000, wd_steps} * 16'(`SPC_WD_STEP_MS));
  assign wd_open   = 16'({11'h000, win_steps} * 16'(`SPC_WD_STEP_MS));
  assign wd_kick   = wr_en && waddr == `SPC_REG_WD_RESTART && wdata == `SPC_WD_KEY;
  assign wd_fail   = ctrl[`SPC_CTRL_WD_EN] && !reset_active
                   && ((ms_tick && (wd_ms + 16'h0001 >= wd_limit))
                   || (wd_kick && (wd_ms < wd_open)));
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ctrl[`SPC_CTRL_WD_EN] || reset_active || wd_kick) begin
      wd_ms <= 16'h0000;
    end else if (ms_tick) begin
      wd_ms <= wd_ms + 16'h0001;
    end
  end

  // Manual reset; own drive holds the debounce count at zero, its echo is masked by the debounce time
  assign mr_trig = ms_tick && (mr_ms == 8'(`SPC_MR_DEBOUNCE_MS - 1));
  always_ff @(posedge mclk_i) begin
    if (srst_i || rstp_f || rst_pin_oe_o) begin
      mr_ms <= 8'h00;
    end else if (ms_tick && mr_ms < 8'(`SPC_MR_DEBOUNCE_MS)) begin
      mr_ms <= mr_ms + 8'h01;
    end
  end

  // Reset generator; hold counts whole ms ticks, so it never exceeds 100 ms
  assign reset_active = vlow_f || (hold_ms != 8'h00);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hold_ms <= 8'h00;
      wd_src  <= 1'b0;
    end else if (vlow_f) begin
      hold_ms <= 8'(`SPC_RST_HOLD_MS);
      wd_src  <= 1'b0;
    end else if (wd_fail) begin
      hold_ms <= 8'(`SPC_WD_PULSE_MS);
      wd_src  <= 1'b1;
    end else if (mr_trig) begin
      hold_ms <= 8'(`SPC_RST_HOLD_MS);
    end else if (ms_tick && hold_ms != 8'h00) begin
      hold_ms <= hold_ms - 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_pin_oe_o <= 1'b0;
    end else begin
      rst_pin_oe_o <= reset_active;
    end
  end
  assign rst_pin_o             = 1'b0;
  assign reset_active_o        = reset_active;
  assign reset_from_watchdog_o = wd_src;
endmodule : spc_top
`default_nettype wire

// File: spc_top_properties.sv
// Pin-level checks of the companion top.
// Assumes it is bound into every spc_top instance.
`timescale 1ns/100ps
`default_nettype none
module spc_top_properties #(
  parameter int MS_CYC = 40000
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_so_oe_o,
  input wire logic standby_o,
  input wire logic supply_low_i,
  input wire logic reset_active_o,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic alarm_cal_wave_output_o,
  input wire logic reset_from_watchdog_o
);
  localparam int HOLD_MAX = 101 * MS_CYC + 8;
  int hold_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Release time after supply returns; slack covers the synchroniser
  always_ff @(posedge mclk_i) begin
    if (srst_i || !reset_active_o || supply_low_i) hold_cnt <= 0;
    else hold_cnt <= hold_cnt + 1;
  end
  sequence s_low;
    supply_low_i [*6];
  endsequence
  property p_float; standby_o |-> !spi_so_oe_o; endproperty
  a_float: assert property (p_float) else $error("output on while idle");
  property p_standby; spi_cs_n_i [*5] |-> standby_o; endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  property p_desel; spi_cs_n_i [*6] |-> !spi_so_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("output on, deselected");
  property p_low; s_low |-> reset_active_o ##1 rst_pin_oe_o; endproperty
  a_low: assert property (p_low) else $error("no reset on low supply");
  property p_src; s_low |-> !reset_from_watchdog_o; endproperty
  a_src: assert property (p_src) else $error("wrong reset source");
  property p_oe; !$past(srst_i) |-> rst_pin_oe_o == $past(reset_active_o); endproperty
  a_oe: assert property (p_oe) else $error("reset pin not following");
  property p_hold; hold_cnt <= HOLD_MAX; endproperty
  a_hold: assert property (p_hold) else $error("reset held too long");
  property p_open; !rst_pin_o && !alarm_cal_wave_output_o; endproperty
  a_open: assert property (p_open) else $error("open drain drives high");
endmodule : spc_top_properties
bind spc_top spc_top_properties #(.MS_CYC(MS_CYC)) chk_u (.mclk_i, .srst_i, .spi_cs_n_i,
  .spi_so_oe_o, .standby_o, .supply_low_i, .reset_active_o, .rst_pin_o, .rst_pin_oe_o,
  .alarm_cal_wave_output_o, .reset_from_watchdog_o);
`default_nettype wire

// File: spc_host.sv
// Serial host model: mode 0 or 3 master, 200 ns clock period.
// Assumes the bench starts one frame at a time.
`timescale 1ns/100ps
`default_nettype none
module spc_host (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic last = 1'b0;
  always @(so_i or so_oe_i) if (so_oe_i) last = so_i;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic frame(input logic cpol, input logic [23:0] tx, output logic [7:0] rx);
    sck_o = cpol;
    #150 cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = tx[i];
      #100 sck_o = 1'b1;
      // Late in the high phase, past the synchroniser delay
      #90 rx = {rx[6:0], so_oe_i ? so_i : ~last};
      #10;
    end
    sck_o = cpol;
    #100 cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask : frame
endmodule : spc_host
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the companion top against a register model.
// Assumes the host model and the bound checker.
`include "spc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int MS = 40;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cs_n, sck, si, so, so_oe, rst_oe, rst_act, wd_src, acs_oe;
  logic pin = 1'b0, low = 1'b0, osc = 1'b0, man_n = 1'b1;
  logic [7:0] mdl [0:31];
  logic [7:0] r;
  logic [15:0] cnt_m = 16'h0000;
  int error_cnt = 0, checked = 0, cyc = 0, n;
  always #12.5 mclk_i = ~mclk_i;
  always #15259 osc = ~osc;
  spc_host host_u (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  spc_top #(.MS_CYC(MS)) dut_u (.mclk_i, .srst_i, .spi_cs_n_i(cs_n), .spi_sck_i(sck),
    .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe), .event_count_input_i(pin),
    .supply_low_i(low), .power_fail_sense_input_i(1'b0), .power_fail_warning_output_n_o(),
    .osc_32k_i(osc), .rst_pin_i(man_n && !rst_oe), .rst_pin_o(), .rst_pin_oe_o(rst_oe),
    .alarm_cal_wave_output_o(), .alarm_cal_wave_output_oe_o(acs_oe), .acs_mode_o(),
    .standby_o(), .reset_active_o(rst_act), .reset_from_watchdog_o(wd_src));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask : tick
  task automatic xfer(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
    host_u.frame(1'($urandom_range(1, 0)), {op, a, d}, r);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(`SPC_OP_WRITE, a, d);
    mdl[a[4:0]] = d;
  endtask : wr
  task automatic cmp(input logic [7:0] a);
    xfer(`SPC_OP_READ, a, 8'h00);
    check(r, mdl[a[4:0]]);
  endtask : cmp
  task automatic cmp_cnt();
    mdl[5] = cnt_m[7:0];
    mdl[6] = cnt_m[15:8];
    cmp(8'h05);
    cmp(8'h06);
  endtask : cmp_cnt
  task automatic toggle();
    pin = ~pin;
    if (pin != mdl[0][1] && (!low || mdl[0][2])) cnt_m++;
    tick(10);
  endtask : toggle
  task automatic await(input logic lvl, input int lim);
    n = 0;
    while (rst_act !== lvl && n < lim) begin
      tick(1);
      n++;
    end
  endtask : await
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    void'($urandom(54814));
    mdl = '{default: 8'h00};
    mdl[1] = 8'h1e;
    mdl[19] = 8'h01;
    mdl[20] = 8'h01;
    mdl[22] = 8'h20;
    tick(2);
    srst_i = 1'b0;
    tick(4);
    for (int a = 0; a < 23; a++) if (a < 3 || a > 15) cmp(8'(a));
    wr(`SPC_REG_CTRL, 8'($urandom) & 8'h7a);
    cmp(`SPC_REG_CTRL);
    foreach (mdl[k]) if (k < 3) xfer(8'h02 + 8'(k), `SPC_REG_CTRL, ~mdl[0]);
    cmp(`SPC_REG_CTRL);
    wr(`SPC_REG_CTRL, 8'h70);
    @(posedge osc) tick(20);
    check({7'h00, acs_oe}, 8'h00);
    @(negedge osc) tick(20);
    check({7'h00, acs_oe}, 8'h01);
    for (int a = 8; a < 16; a++) wr(8'(a), 8'($urandom));
    for (int a = 8; a < 16; a++) cmp(8'(a));
    wr(`SPC_REG_SN_LOCK, 8'h01);
    xfer(`SPC_OP_WRITE, 8'h08, ~mdl[8]);
    cmp(8'h08);
    xfer(`SPC_OP_READ, `SPC_REG_STATUS, 8'h00);
    check(r, 8'h08);
    for (int p = 0; p < 2; p++) begin
      wr(`SPC_REG_CTRL, 8'(p * 2));
      repeat ($urandom_range(20, 1)) toggle();
      cmp_cnt();
      check({7'h00, acs_oe}, 8'h00);
    end
    wr(`SPC_REG_CTRL, 8'h04);
    low = 1'b1;
    tick(8);
    check({7'h00, rst_oe}, 8'h01);
    xfer(`SPC_OP_WRITE, `SPC_REG_CTRL, 8'h00);
    repeat (5) toggle();
    check({7'h00, wd_src}, 8'h00);
    low = 1'b0;
    await(1'b0, 102 * MS);
    check(8'(n >= 98 * MS && n <= 101 * MS), 8'h01);
    cmp_cnt();
    cmp(`SPC_REG_CTRL);
    man_n = 1'b0;
    tick(2 * MS);
    man_n = 1'b1;
    tick(MS);
    check({7'h00, rst_act}, 8'h00);
    man_n = 1'b0;
    await(1'b1, 12 * MS);
    man_n = 1'b1;
    check(8'(rst_act === 1'b1 && n >= 9 * MS), 8'h01);
    await(1'b0, 102 * MS);
    wr(`SPC_REG_WD_TIMEOUT, 8'h02);
    wr(`SPC_REG_WD_WINDOW, 8'h01);
    wr(`SPC_REG_CTRL, 8'h01);
    tick(30 * MS);
    wr(`SPC_REG_WD_RESTART, `SPC_WD_KEY);
    await(1'b1, 20 * MS);
    check({7'h00, rst_act}, 8'h01);
    check({7'h00, wd_src}, 8'h01);
    await(1'b0, 102 * MS);
    check(8'(n >= 98 * MS), 8'h01);
    wr(`SPC_REG_CTRL, 8'h00);
    wr(`SPC_REG_CTRL, 8'h01);
    tick(80 * MS);
    wr(`SPC_REG_WD_RESTART, `SPC_WD_KEY);
    tick(MS);
    check({7'h00, rst_act}, 8'h00);
    await(1'b1, 130 * MS);
    check(8'(n >= 117 * MS && n <= 121 * MS), 8'h01);
    await(1'b0, 102 * MS);
    wr(`SPC_REG_CTRL, 8'h00);
    tick(130 * MS);
    check({7'h00, rst_act}, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
